// file: logic/irqrs_top.sv
// irq pin unit, reset cause register and watchdog service on an avalon-mm slave
//
// Summary of operation
// - pin enabled with pull disable set turns both pull devices off
// - polarity 0 picks falling edges or low levels, 1 rising or high
// - enabled pin pulls down for rising detection, up for falling detection
// - pin enable 0 stops the pin from raising requests
// - request flag is read only and shows a detected request event
// - writing 1 to acknowledge clears the flag; it reads back 0
// - in edge-and-level mode acknowledge fails while pin stays asserted
// - interrupt enable drives the interrupt request whenever the flag is set
// - detection mode 0 is edge only, 1 is edge plus level
// - reset cause register holds read-only flags of the latest reset source
// - a debug forced reset leaves every cause flag cleared
// - with watchdog on, writing a non service value to cause address resets
// - writing first then second service value restarts the watchdog count
// - power-on reset sets power-on and low voltage flags only
// - low voltage trip with its reset enabled resets and sets its flag
// - other resets set each flag whose source is active at entry
// - external reset pin request sets the pin flag
// - watchdog timeout sets its flag; no such reset when watchdog is off
// - illegal opcode, disallowed stop or background instruction set opcode flag
// - access to an unimplemented address sets the illegal address flag
// - loss of the external clock sets the clock loss flag
// - in window mode any cause write before the last quarter resets
`timescale 1ns/1ps
`include "irqrs_consts.svh"

module irqrs_top
  import irqrs_pkg::*;
#(
  parameter int unsigned WDOG_TIMEOUT = `IRQRS_WDOG_TIMEOUT
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic irq_pin,
  output logic pull_up_enable,
  output logic pull_down_enable,
  output logic irq_request,
  input wire logic ext_reset_req,
  input wire logic illegal_opcode_event,
  input wire logic stop_instruction,
  input wire logic stop_allow,
  input wire logic background_instruction,
  input wire logic background_mode_allow,
  input wire logic illegal_address_event,
  input wire logic clock_loss_event,
  input wire logic low_voltage_trip,
  input wire logic debug_force_reset,
  output logic system_reset
);

  localparam int CW = $clog2(WDOG_TIMEOUT + 1);
  localparam logic [CW-1:0] WD_LAST = CW'(WDOG_TIMEOUT - 1);
  localparam logic [CW-1:0] WD_OPEN = CW'(WDOG_TIMEOUT - WDOG_TIMEOUT / 4);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  irqrs_irqctl_t irq_ctl;
  irqrs_cause_t cause;
  irqrs_svc_t svc_state;
  logic request_flag;
  logic watchdog_enable;
  logic watchdog_window_mode;
  logic low_voltage_reset_enable;
  logic [CW-1:0] wd_count;
  logic pin_meta;
  logic pin_sync;
  logic prev_active;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wr_fire;
  logic rd_take;
  logic lane0;
  logic [7:0] wbyte;
  logic hit_irq;
  logic hit_cause;
  logic hit_sysctl;

  // a write takes effect at the edge where waitrequest is seen low; a read is sampled at the edge before, while it is high
  assign wr_fire = clk_en && avs_write && !avs_waitrequest;
  assign rd_take = clk_en && avs_read && avs_waitrequest;
  assign lane0 = avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  assign hit_irq = (avs_address == `IRQRS_OFF_IRQ);
  assign hit_cause = (avs_address == `IRQRS_OFF_CAUSE);
  assign hit_sysctl = (avs_address == `IRQRS_OFF_SYSCTL);

  // ----------------------------------------------------------------
  // irq pin detection
  // ----------------------------------------------------------------
  logic active_lvl;
  logic edge_seen;
  logic set_req;
  logic ack_req;

  // xnor folds polarity so one detector serves both senses
  assign active_lvl = pin_sync ~^ irq_ctl.polarity_select;
  assign edge_seen = active_lvl && !prev_active;
  assign set_req = irq_ctl.pin_function_enable &&
                   (edge_seen || (irq_ctl.detection_mode && active_lvl));
  assign ack_req = wr_fire && hit_irq && lane0 && wbyte[`IRQRS_IRQ_ACK];

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  logic cause_wr;
  logic svc_value;
  logic wd_bad_write;
  logic wd_timeout;
  logic wdog_src;
  logic opcode_src;
  logic lv_src;
  logic reset_entry;
  logic svc_done;
  irqrs_cause_t next_cause;

  assign cause_wr = wr_fire && hit_cause && lane0;
  assign svc_value = (wbyte == `IRQRS_SVC_FIRST) || (wbyte == `IRQRS_SVC_SECOND);
  // early writes in window mode are treated as a failed service
  assign wd_bad_write = watchdog_enable && cause_wr &&
                        (!svc_value || (watchdog_window_mode && wd_count < WD_OPEN));
  assign wd_timeout = watchdog_enable && (wd_count == WD_LAST);
  assign wdog_src = wd_bad_write || wd_timeout;
  assign opcode_src = illegal_opcode_event ||
                    (stop_instruction && !stop_allow) ||
                    (background_instruction && !background_mode_allow);
  assign lv_src = low_voltage_trip && low_voltage_reset_enable;
  assign reset_entry = ext_reset_req || wdog_src || opcode_src || illegal_address_event ||
                       clock_loss_event || lv_src || debug_force_reset;
  assign svc_done = cause_wr && !wd_bad_write && svc_state == IRQRS_SVC_ARMED &&
                    wbyte == `IRQRS_SVC_SECOND;

  // cause capture at reset entry; debug wins, then low voltage
  always_comb begin
    next_cause = '0;
    if (debug_force_reset) begin
      next_cause = '0;
    end else if (lv_src) begin
      next_cause.por = cause.por; // power-on flag left as it stood
      next_cause.low_voltage_flag = 1'b1;
    end else begin
      next_cause.pin = ext_reset_req;
      next_cause.wdog = wdog_src;
      next_cause.illegal_opcode_flag = opcode_src;
      next_cause.illegal_address_flag = illegal_address_event;
      next_cause.clock_loss_flag = clock_loss_event;
    end
  end

  // ----------------------------------------------------------------
  // pin synchroniser and edge history
  // ----------------------------------------------------------------
  // first stage feeds only the second; detection reads pin_sync
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else if (clk_en) begin
      pin_meta <= irq_pin;
      pin_sync <= pin_meta;
    end
  end

  // history starts as active so a pin already asserted is not an edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prev_active <= 1'b1;
    end else if (clk_en) begin
      prev_active <= active_lvl;
    end
  end

  // ----------------------------------------------------------------
  // irq control and flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_ctl <= '0;
    end else if (clk_en) begin
      if (reset_entry) begin
        irq_ctl <= '0;
      end else if (wr_fire && hit_irq && lane0) begin
        irq_ctl.pull_disable <= wbyte[`IRQRS_IRQ_PDD];
        irq_ctl.polarity_select <= wbyte[`IRQRS_IRQ_POL];
        irq_ctl.pin_function_enable <= wbyte[`IRQRS_IRQ_PE];
        irq_ctl.request_interrupt_enable <= wbyte[`IRQRS_IRQ_IE];
        irq_ctl.detection_mode <= wbyte[`IRQRS_IRQ_MOD];
      end
    end
  end

  // a set in the same cycle as an acknowledge wins, so no event is lost
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      request_flag <= 1'b0;
    end else if (clk_en) begin
      if (reset_entry) begin
        request_flag <= 1'b0;
      end else if (set_req) begin
        request_flag <= 1'b1;
      end else if (ack_req) begin
        request_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // system control and reset cause
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_enable <= 1'b0;
      watchdog_window_mode <= 1'b0;
      low_voltage_reset_enable <= 1'b0;
    end else if (clk_en) begin
      if (reset_entry) begin
        watchdog_enable <= 1'b0;
        watchdog_window_mode <= 1'b0;
        low_voltage_reset_enable <= 1'b0;
      end else if (wr_fire && hit_sysctl && lane0) begin
        watchdog_enable <= wbyte[`IRQRS_SYS_WDE];
        watchdog_window_mode <= wbyte[`IRQRS_SYS_WDW];
        low_voltage_reset_enable <= wbyte[`IRQRS_SYS_LVRE];
      end
    end
  end

  // reset_n is the power-on reset; software writes never store here
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cause <= `IRQRS_CAUSE_POR_VAL;
    end else if (clk_en && reset_entry) begin
      cause <= next_cause;
    end
  end

  // ----------------------------------------------------------------
  // watchdog count and service sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wd_count <= '0;
    end else if (clk_en) begin
      if (reset_entry || svc_done || !watchdog_enable) begin
        wd_count <= '0;
      end else begin
        wd_count <= wd_count + 1'b1;
      end
    end
  end

  // only a first value arms; the second value alone does nothing
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      svc_state <= IRQRS_SVC_IDLE;
    end else if (clk_en) begin
      if (reset_entry || svc_done) begin
        svc_state <= IRQRS_SVC_IDLE;
      end else if (cause_wr && wbyte == `IRQRS_SVC_FIRST) begin
        svc_state <= IRQRS_SVC_ARMED;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pulls follow detection sense; disabled pin leaves the pad floating
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pull_up_enable <= 1'b0;
      pull_down_enable <= 1'b0;
    end else if (clk_en) begin
      pull_up_enable <= irq_ctl.pin_function_enable && !irq_ctl.pull_disable &&
                        !irq_ctl.polarity_select;
      pull_down_enable <= irq_ctl.pin_function_enable && !irq_ctl.pull_disable &&
                          irq_ctl.polarity_select;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_request <= 1'b0;
      system_reset <= 1'b0;
    end else if (clk_en) begin
      irq_request <= request_flag && irq_ctl.request_interrupt_enable;
      system_reset <= reset_entry;
    end
  end

  // one wait cycle per access; the answer lands at the following edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // unmapped addresses read zero; acknowledge always reads zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= '0;
    end else if (rd_take) begin
      if (hit_irq) begin
        avs_readdata <= {25'h0000000, irq_ctl.pull_disable, irq_ctl.polarity_select,
                         irq_ctl.pin_function_enable, request_flag, 1'b0,
                         irq_ctl.request_interrupt_enable, irq_ctl.detection_mode};
      end else if (hit_cause) begin
        avs_readdata <= {24'h000000, cause};
      end else if (hit_sysctl) begin
        avs_readdata <= {29'h00000000, low_voltage_reset_enable, watchdog_window_mode,
                         watchdog_enable};
      end else begin
        avs_readdata <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_arm;
    cause_wr && !wd_bad_write && wbyte == `IRQRS_SVC_FIRST;
  endsequence

  sequence s_second;
    clk_en && !reset_entry && svc_state == IRQRS_SVC_ARMED && cause_wr && !wd_bad_write &&
      wbyte == `IRQRS_SVC_SECOND;
  endsequence

  property p_pull_off;
    clk_en && irq_ctl.pin_function_enable && irq_ctl.pull_disable |=>
      !pull_up_enable && !pull_down_enable;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull left on");

  property p_pull_dir;
    clk_en && irq_ctl.pin_function_enable && !irq_ctl.pull_disable |=>
      pull_down_enable == $past(irq_ctl.polarity_select) && pull_up_enable != pull_down_enable;
  endproperty
  a_pull_dir: assert property (p_pull_dir) else $error("wrong pull device");

  property p_edge_sets;
    clk_en && !reset_entry && irq_ctl.pin_function_enable && active_lvl && !prev_active
      |=> request_flag;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge missed");

  property p_pin_off;
    clk_en && !irq_ctl.pin_function_enable && !request_flag |=> !request_flag;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("flag set while pin off");

  property p_ack_clears;
    clk_en && ack_req && !set_req && !reset_entry |=> !request_flag ##1 !irq_request;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack failed");

  property p_level_holds;
    clk_en && !reset_entry && request_flag && irq_ctl.pin_function_enable &&
      irq_ctl.detection_mode && active_lvl |=> request_flag;
  endproperty
  a_level_holds: assert property (p_level_holds) else $error("flag cleared at level");

  property p_irq_out;
    clk_en && request_flag && irq_ctl.request_interrupt_enable |=> irq_request;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq request missing");

  property p_debug;
    clk_en && debug_force_reset |=> cause == '0 && system_reset;
  endproperty
  a_debug: assert property (p_debug) else $error("debug reset left flags");

  property p_bad_write;
    clk_en && watchdog_enable && cause_wr && !svc_value && !debug_force_reset && !lv_src
      |=> system_reset && cause.wdog;
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("bad write not reset");

  property p_service;
    s_arm ##[1:1000] s_second |=> wd_count == '0 && $stable(cause);
  endproperty
  a_service: assert property (p_service) else $error("service failed");

  property p_pin_cause;
    clk_en && ext_reset_req && !debug_force_reset && !lv_src |=> cause.pin && system_reset;
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin flag missing");

  property p_timeout;
    clk_en && watchdog_enable && wd_count == WD_LAST && !debug_force_reset && !lv_src
      |=> cause.wdog && wd_count == '0;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not reset");

  property p_window;
    clk_en && watchdog_enable && watchdog_window_mode && cause_wr && wd_count < WD_OPEN
      |=> system_reset;
  endproperty
  a_window: assert property (p_window) else $error("early write not reset");

endmodule : irqrs_top

// file: logic/irqrs_consts.svh
// offsets, field positions, reset values and codes of the irq pin and reset cause bank
`ifndef IRQRS_CONSTS_SVH
`define IRQRS_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IRQRS_OFF_IRQ 4'h0
`define IRQRS_OFF_CAUSE 4'h4
`define IRQRS_OFF_SYSCTL 4'h8

// ----------------------------------------------------------------
// irq_pin_control_status fields
// ----------------------------------------------------------------
`define IRQRS_IRQ_PDD 6
`define IRQRS_IRQ_POL 5
`define IRQRS_IRQ_PE 4
`define IRQRS_IRQ_FLAG 3
`define IRQRS_IRQ_ACK 2
`define IRQRS_IRQ_IE 1
`define IRQRS_IRQ_MOD 0

// ----------------------------------------------------------------
// system control fields
// ----------------------------------------------------------------
`define IRQRS_SYS_WDE 0
`define IRQRS_SYS_WDW 1
`define IRQRS_SYS_LVRE 2

// ----------------------------------------------------------------
// reset values and service codes
// ----------------------------------------------------------------
`define IRQRS_CAUSE_POR_VAL 8'h82
`define IRQRS_SVC_FIRST 8'h55
`define IRQRS_SVC_SECOND 8'hAA
`define IRQRS_WDOG_TIMEOUT 8192

`endif

// file: logic/irqrs_pkg.sv
// types shared by the irq pin and reset cause bank
package irqrs_pkg;

  // reset cause flags in register bit order, bit 7 first
  typedef struct packed {
    logic por;
    logic pin;
    logic wdog;
    logic illegal_opcode_flag;
    logic illegal_address_flag;
    logic clock_loss_flag;
    logic low_voltage_flag;
    logic zero;
  } irqrs_cause_t;

  // control bits of the irq pin unit
  typedef struct packed {
    logic pull_disable;
    logic polarity_select;
    logic pin_function_enable;
    logic request_interrupt_enable;
    logic detection_mode;
  } irqrs_irqctl_t;

  // watchdog service sequence tracker
  typedef enum logic [0:0] {
    IRQRS_SVC_IDLE = 1'b0,
    IRQRS_SVC_ARMED = 1'b1
  } irqrs_svc_t;

endpackage : irqrs_pkg

// file: testbench/irqrs_pin_source.sv
// far-side model of the external source on the request pin
`timescale 1ns/1ps
module irqrs_pin_source (
  input wire logic clk_sys,
  input wire logic drive_en,
  input wire logic drive_val,
  input wire logic pull_up_enable,
  input wire logic pull_down_enable,
  output logic irq_pin
);
  // ----------------------------------------------------------------
  // pin level
  // ----------------------------------------------------------------
  logic float_val = 1'b0;

  // an undriven pin without a pull must not look stable to the design
  always_ff @(posedge clk_sys) begin
    float_val <= ~float_val;
  end

  // the source wins, then the pull device, else the wandering level
  always_comb begin
    if (drive_en) begin
      irq_pin = drive_val;
    end else if (pull_up_enable) begin
      irq_pin = 1'b1;
    end else if (pull_down_enable) begin
      irq_pin = 1'b0;
    end else begin
      irq_pin = float_val;
    end
  end
endmodule : irqrs_pin_source

// file: testbench/irqrs_top_bench.sv
// self-checking bench for the irq pin and reset cause bank
`timescale 1ns/1ps
module irqrs_top_bench;
  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq_pin, pull_up_enable, pull_down_enable, irq_request, system_reset;
  logic [7:0] src = 8'h00; // one bit per reset source
  logic stop_allow = 1'b0;
  logic bg_allow = 1'b0;
  logic drive_en = 1'b0;
  logic drive_val = 1'b0;
  logic [7:0] cause_tab [8] = '{8'h40, 8'h10, 8'h10, 8'h10, 8'h08, 8'h04, 8'h02, 8'h00};
  logic [31:0] exp_q[$];
  int fails = 0;
  int total_checks = 0;
  int resets = 0;
  int seed = 25639;

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // short watchdog period keeps the timeout and window runs brief
  irqrs_top #(.WDOG_TIMEOUT(64)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_pin(irq_pin), .pull_up_enable(pull_up_enable),
    .pull_down_enable(pull_down_enable), .irq_request(irq_request),
    .ext_reset_req(src[0]), .illegal_opcode_event(src[1]), .stop_instruction(src[2]),
    .stop_allow(stop_allow), .background_instruction(src[3]),
    .background_mode_allow(bg_allow), .illegal_address_event(src[4]),
    .clock_loss_event(src[5]), .low_voltage_trip(src[6]),
    .debug_force_reset(src[7]), .system_reset(system_reset)
  );

  irqrs_pin_source partner (
    .clk_sys(clk_sys), .drive_en(drive_en), .drive_val(drive_val),
    .pull_up_enable(pull_up_enable), .pull_down_enable(pull_down_enable),
    .irq_pin(irq_pin)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : cmp

  task automatic results();
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // idle ends just past an edge so port outputs are settled when looked at
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  // one avalon access; unused data lanes carry random bits
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    logic [31:0] r;
    n = 0;
    r = $random(seed);
    @(posedge clk_sys);
    avs_write <= wr;
    avs_read <= ~wr;
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= {r[31:8], d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      fails++;
      results();
    end
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00, 4'hF);
  endtask : rd

  task automatic pin(input logic en, input logic v);
    @(posedge clk_sys);
    drive_en <= en;
    drive_val <= v;
    idle(6);
  endtask : pin

  task automatic pulse(input int i);
    @(posedge clk_sys);
    src[i] <= 1'b1;
    @(posedge clk_sys);
    src[i] <= 1'b0;
    idle(3);
  endtask : pulse

  // monitor: counts reset pulses and matches read data to the oldest note
  always @(posedge clk_sys) begin
    if (system_reset === 1'b1) begin
      resets++;
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("unexpected at %0t: read with no note", $time);
      end else begin
        cmp(avs_readdata, exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(4'h4, 8'h82);
    rd(4'h0, 8'h00);
    rd(4'hC, 8'h00);
    bus(1'b1, 4'h0, 8'h12, 4'hE);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h12);
    idle(2);
    cmp({pull_up_enable, pull_down_enable}, 2'b10);
    pin(1'b1, 1'b0);
    rd(4'h0, 8'h1A);
    idle(1);
    cmp(irq_request, 1'b1);
    wr(4'h0, 8'h16);
    rd(4'h0, 8'h12);
    idle(1);
    cmp(irq_request, 1'b0);
    wr(4'h0, 8'h31);
    idle(1);
    cmp({pull_up_enable, pull_down_enable}, 2'b01);
    pin(1'b1, 1'b1);
    wr(4'h0, 8'h35);
    rd(4'h0, 8'h39);
    idle(1);
    cmp(irq_request, 1'b0);
    pin(1'b1, 1'b0);
    wr(4'h0, 8'h35);
    rd(4'h0, 8'h31);
    wr(4'h0, 8'h00);
    pin(1'b1, 1'b1);
    wr(4'h0, 8'h50);
    idle(1);
    cmp({pull_up_enable, pull_down_enable}, 2'b00);
    wr(4'h0, 8'h04);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    rd(4'h0, 8'h00);
    pulse(6);
    cmp(resets, 0);
    wr(4'h8, 8'h04);
    pulse(6);
    cmp(resets, 1);
    rd(4'h4, 8'h82);
    wr(4'h4, 8'h00);
    rd(4'h4, 8'h82);
    stop_allow <= 1'b1;
    bg_allow <= 1'b1;
    pulse(2);
    pulse(3);
    cmp(resets, 1);
    @(posedge clk_sys);
    stop_allow <= 1'b0;
    bg_allow <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i != 6) begin
        pulse(i);
        rd(4'h4, cause_tab[i]);
      end
    end
    cmp(resets, 8);
    wr(4'h8, 8'h01);
    wr(4'h4, 8'h55);
    wr(4'h4, 8'hAA);
    idle(40);
    wr(4'h4, 8'h55);
    wr(4'h4, 8'hAA);
    idle(30);
    cmp(resets, 8);
    rd(4'h4, 8'h00);
    wr(4'h4, 8'h12);
    idle(3);
    cmp(resets, 9);
    rd(4'h4, 8'h20);
    wr(4'h8, 8'h01);
    idle(70);
    cmp(resets, 10);
    rd(4'h4, 8'h20);
    wr(4'h8, 8'h03);
    wr(4'h4, 8'h55);
    idle(3);
    cmp(resets, 11);
    wr(4'h8, 8'h03);
    idle(48);
    wr(4'h4, 8'h55);
    wr(4'h4, 8'hAA);
    idle(3);
    wr(4'h8, 8'h00);
    idle(3);
    cmp(resets, 11);
    if (exp_q.size() != 0) begin
      fails++;
    end
    results();
  end
endmodule : irqrs_top_bench
